/* File: core/nvac_defs.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 250 MHz ref_clk_i, I/O register port of the CPU core
// Notes: included by the timer, control and bench files
//
// Functional notes
// - address bits 15:12 read zero; 11:0 select byte
// - write takes data reg; read fills it
// - mode: 00 erase+write, 01 erase, 10 write
// - mode writes ignored while write strobe set
// - reset clears mode unless programming busy
// - ready irq level while strobe clear, enabled
// - strobe starts only within master enable window
// - master enable self-clears after four cycles
// - strobe stays set until programming time elapses
// - write start stalls CPU two cycles
// - read fetches byte, stalls CPU four cycles
// - busy: refuse reads, freeze address register
// - no EEPROM write while flash self-programming
// - programming timed in RC oscillator cycles
// - control bits 7:6 read zero
// - reset never aborts running programming
`ifndef NVAC_DEFS_SVH
`define NVAC_DEFS_SVH

`define NVAC_OFF_CTRL 6'h1F
`define NVAC_OFF_DATA 6'h20
`define NVAC_OFF_ADDR_LO 6'h21
`define NVAC_OFF_ADDR_HI 6'h22

`define NVAC_CTRL_RE 0
`define NVAC_CTRL_PE 1
`define NVAC_CTRL_MPE 2
`define NVAC_CTRL_RIE 3
`define NVAC_CTRL_PM_LO 4
`define NVAC_CTRL_PM_HI 5

`define NVAC_MODE_RST 2'h0
`define NVAC_DATA_RST 8'h00
`define NVAC_ERASED 8'hFF

`define NVAC_MPE_WINDOW 4
`define NVAC_WR_STALL 2
`define NVAC_RD_STALL 4

`define NVAC_CLK_KHZ 250000
`define NVAC_ATOMIC_TIME_US 3400
`define NVAC_SPLIT_TIME_US 1800
`define NVAC_ATOMIC_TYP_US 3300
`define NVAC_RC_CYC_ATOMIC 26368
`define NVAC_RC_CYC_SPLIT \
  (`NVAC_RC_CYC_ATOMIC * `NVAC_SPLIT_TIME_US / `NVAC_ATOMIC_TIME_US)
`define NVAC_RC_DIV \
  ((`NVAC_CLK_KHZ * `NVAC_ATOMIC_TYP_US) / (`NVAC_RC_CYC_ATOMIC * 1000))

`endif

/* File: core/nvac_pkg.sv */
// Purpose: types shared by the data EEPROM access block
// Assumes: nothing beyond the defs header
// Notes: one-hot state codes written out
package nvac_pkg;

  typedef enum logic [1:0] {
    NVAC_IDLE = 2'b01,
    NVAC_PROG = 2'b10
  } nvac_state_t;

  typedef enum logic [1:0] {
    NVAC_PM_ATOMIC = 2'b00,
    NVAC_PM_ERASE = 2'b01,
    NVAC_PM_WRITE = 2'b10,
    NVAC_PM_RESV = 2'b11
  } nvac_mode_t;

endpackage : nvac_pkg

/* File: core/nvac_rc_timer.sv */
// Purpose: programming-time counter on the calibrated RC tick
// Assumes: RC tick derived from ref_clk_i by a divider
// Notes: owner gates sys_rst_i off while a program runs
`timescale 1ns/1ps
`include "nvac_defs.svh"
module nvac_rc_timer #(
  parameter logic [5:0] DIV = 6'(`NVAC_RC_DIV)
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [15:0] len_i,
  output logic busy_o,
  output logic done_o
);
  logic [5:0] div_q;
  logic [15:0] cnt_q;
  wire rc_tick = (div_q == 6'h00);

  // free-running stand-in for the RC oscillator edge
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || rc_tick) begin
      div_q <= DIV - 6'h01;
    end else begin
      div_q <= div_q - 6'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    done_o <= 1'b0;
    if (sys_rst_i) begin
      busy_o <= 1'b0;
      cnt_q <= 16'h0000;
    end else if (start_i && !busy_o) begin
      busy_o <= 1'b1;
      cnt_q <= len_i;
    end else if (busy_o && rc_tick) begin
      cnt_q <= cnt_q - 16'h0001;
      if (cnt_q == 16'h0001) begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end
    end
  end
endmodule : nvac_rc_timer

/* File: core/nvac_byte_store.sv */
// Purpose: byte array standing in for the data EEPROM cells
// Assumes: one write port, two combinational read ports
// Notes: no reset, contents are meant to survive it
`timescale 1ns/1ps
module nvac_byte_store (
  input wire logic ref_clk_i,
  input wire logic we_i,
  input wire logic [11:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  output logic [7:0] wr_old_o,
  input wire logic [11:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem_q [4096];

  assign wr_old_o = mem_q[wr_addr_i];
  assign rd_data_o = mem_q[rd_addr_i];

  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end
endmodule : nvac_byte_store

/* File: core/nvac_ctrl.sv */
// Purpose: CPU-facing data EEPROM access control
// Assumes: I/O register port on ref_clk_i, one access per cycle
// Notes: read data returns one cycle after io_rd_i
`timescale 1ns/1ps
`include "nvac_defs.svh"
module nvac_ctrl
  import nvac_pkg::*;
#(
  parameter logic [15:0] ATOMIC_RC_CYC = 16'(`NVAC_RC_CYC_ATOMIC),
  parameter logic [15:0] SPLIT_RC_CYC = 16'(`NVAC_RC_CYC_SPLIT)
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [5:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic gie_i,
  input wire logic flash_selfprog_busy_i,
  output logic nvm_ready_irq_o,
  output logic cpu_stall_o
);

  function automatic logic nvac_hit(input logic [5:0] a,
                                    input logic [5:0] off);
    nvac_hit = (a == off);
  endfunction : nvac_hit

  // erase leaves all ones; a plain write can only clear bits
  function automatic logic [7:0] nvac_prog_byte(input nvac_mode_t m,
                                                input logic [7:0] old,
                                                input logic [7:0] nw);
    unique case (m)
      NVAC_PM_ATOMIC: nvac_prog_byte = nw;
      NVAC_PM_ERASE: nvac_prog_byte = `NVAC_ERASED;
      NVAC_PM_WRITE: nvac_prog_byte = old & nw;
      NVAC_PM_RESV: nvac_prog_byte = old;
    endcase
  endfunction : nvac_prog_byte

  function automatic logic [15:0] nvac_prog_len(input nvac_mode_t m);
    nvac_prog_len = (m == NVAC_PM_ATOMIC) ? ATOMIC_RC_CYC : SPLIT_RC_CYC;
  endfunction : nvac_prog_len

  nvac_state_t st_q;
  nvac_state_t st_d;
  nvac_mode_t mode_q;
  nvac_mode_t op_mode_q;
  logic [11:0] addr_q;
  logic [11:0] op_addr_q;
  logic [7:0] data_q;
  logic [7:0] op_data_q;
  logic rie_q;
  logic mpe_q;
  logic [2:0] mpe_cnt_q;
  logic [2:0] stall_cnt_q;
  logic [7:0] mem_rd;
  logic [7:0] mem_old;
  logic tmr_busy;
  logic tmr_done;

  wire prog_busy = (st_q == NVAC_PROG);
  // timer keeps counting through a reset that meets a running program;
  // its own busy flag starts unknown, so it must not decide this itself
  wire tmr_rst = sys_rst_i && (st_q != NVAC_PROG);
  wire ctrl_wr = io_wr_i && nvac_hit(io_addr_i, `NVAC_OFF_CTRL);
  wire data_wr = io_wr_i && nvac_hit(io_addr_i, `NVAC_OFF_DATA);
  wire lo_wr = io_wr_i && nvac_hit(io_addr_i, `NVAC_OFF_ADDR_LO);
  wire hi_wr = io_wr_i && nvac_hit(io_addr_i, `NVAC_OFF_ADDR_HI);
  wire mpe_wr = ctrl_wr && io_wdata_i[`NVAC_CTRL_MPE];
  wire pe_wr = ctrl_wr && io_wdata_i[`NVAC_CTRL_PE];
  wire re_wr = ctrl_wr && io_wdata_i[`NVAC_CTRL_RE];
  wire [1:0] pm_wr = io_wdata_i[`NVAC_CTRL_PM_HI:`NVAC_CTRL_PM_LO];
  // strobe counts only inside the enable window and outside flash
  // self-programming; the reserved mode code starts nothing
  wire start_ok = pe_wr && mpe_q && !prog_busy
                  && !flash_selfprog_busy_i
                  && mode_q != NVAC_PM_RESV;
  wire read_ok = re_wr && !prog_busy;
  wire [7:0] ctrl_view = {2'b00, mode_q, rie_q, mpe_q,
                          prog_busy, 1'b0};
  wire [7:0] rd_mux =
    nvac_hit(io_addr_i, `NVAC_OFF_ADDR_LO) ? addr_q[7:0] :
    nvac_hit(io_addr_i, `NVAC_OFF_ADDR_HI) ?
      {4'h0, addr_q[11:8]} :
    nvac_hit(io_addr_i, `NVAC_OFF_DATA) ? data_q :
    nvac_hit(io_addr_i, `NVAC_OFF_CTRL) ? ctrl_view : 8'h00;

  nvac_rc_timer u_timer (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(tmr_rst),
    .start_i(start_ok),
    .len_i(nvac_prog_len(mode_q)),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  nvac_byte_store u_store (
    .ref_clk_i(ref_clk_i),
    .we_i(tmr_done),
    .wr_addr_i(op_addr_q),
    .wr_data_i(nvac_prog_byte(op_mode_q, mem_old, op_data_q)),
    .wr_old_o(mem_old),
    .rd_addr_i(addr_q),
    .rd_data_o(mem_rd)
  );

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      NVAC_IDLE: begin
        if (start_ok) begin
          st_d = NVAC_PROG;
        end
      end
      NVAC_PROG: begin
        if (tmr_done) begin
          st_d = NVAC_IDLE;
        end
      end
      default: st_d = NVAC_IDLE;
    endcase
  end

  // an unknown power-up state counts as idle, a running program
  // survives reset
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i && st_q != NVAC_PROG) begin
      st_q <= NVAC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      if (!prog_busy) begin
        mode_q <= nvac_mode_t'(`NVAC_MODE_RST);
      end
    end else if (ctrl_wr && !prog_busy) begin
      mode_q <= nvac_mode_t'(pm_wr);
    end
  end

  // operands are captured at the strobe so later data writes
  // cannot disturb a running program
  always_ff @(posedge ref_clk_i) begin
    if (start_ok) begin
      op_addr_q <= addr_q;
      op_data_q <= data_q;
      op_mode_q <= mode_q;
    end
  end

  // address has no reset value; software loads it first
  always_ff @(posedge ref_clk_i) begin
    if (lo_wr && !prog_busy) begin
      addr_q[7:0] <= io_wdata_i;
    end
    if (hi_wr && !prog_busy) begin
      addr_q[11:8] <= io_wdata_i[3:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      data_q <= `NVAC_DATA_RST;
    end else if (read_ok) begin
      data_q <= mem_rd;
    end else if (data_wr) begin
      data_q <= io_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rie_q <= 1'b0;
    end else if (ctrl_wr) begin
      rie_q <= io_wdata_i[`NVAC_CTRL_RIE];
    end
  end

  // enable stays high for four cycles after the write
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      mpe_q <= 1'b0;
      mpe_cnt_q <= 3'h0;
    end else if (mpe_wr) begin
      mpe_q <= 1'b1;
      mpe_cnt_q <= 3'(`NVAC_MPE_WINDOW - 1);
    end else if (mpe_q) begin
      if (mpe_cnt_q == 3'h0) begin
        mpe_q <= 1'b0;
      end else begin
        mpe_cnt_q <= mpe_cnt_q - 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cpu_stall_o <= 1'b0;
      stall_cnt_q <= 3'h0;
    end else if (start_ok) begin
      cpu_stall_o <= 1'b1;
      stall_cnt_q <= 3'(`NVAC_WR_STALL - 1);
    end else if (read_ok) begin
      cpu_stall_o <= 1'b1;
      stall_cnt_q <= 3'(`NVAC_RD_STALL - 1);
    end else begin
      cpu_stall_o <= (stall_cnt_q != 3'h0);
      if (stall_cnt_q != 3'h0) begin
        stall_cnt_q <= stall_cnt_q - 3'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      io_rdata_o <= 8'h00;
    end else if (io_rd_i) begin
      io_rdata_o <= rd_mux;
    end
  end

  // level request, no sticky flag: it follows the strobe one cycle later
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      nvm_ready_irq_o <= 1'b0;
    end else begin
      nvm_ready_irq_o <= rie_q && gie_i && !prog_busy;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_mpe_quiet;
    !mpe_wr [*4];
  endsequence

  sequence s_stall_two;
    cpu_stall_o [*2] ##1 !cpu_stall_o;
  endsequence

  sequence s_stall_four;
    cpu_stall_o [*4] ##1 !cpu_stall_o;
  endsequence

  a_resv_addr_zero: assert property (
    io_rd_i && nvac_hit(io_addr_i, `NVAC_OFF_ADDR_HI)
    |=> io_rdata_o[7:4] == 4'h0)
    else $error("address high reserved bits not zero");

  a_resv_ctrl_zero: assert property (
    io_rd_i && nvac_hit(io_addr_i, `NVAC_OFF_CTRL)
    |=> io_rdata_o[7:6] == 2'b00)
    else $error("control reserved bits not zero");

  a_read_fetch: assert property (
    read_ok |=> data_q == $past(mem_rd))
    else $error("read did not load the data register");

  a_mode_locked: assert property (
    ctrl_wr && prog_busy |=> mode_q == $past(mode_q))
    else $error("mode changed while programming");

  a_mode_reset: assert property (
    disable iff (1'b0)
    sys_rst_i && !prog_busy |=> mode_q == NVAC_PM_ATOMIC)
    else $error("mode not cleared by reset");

  a_reset_no_abort: assert property (
    disable iff (1'b0)
    sys_rst_i && prog_busy && !tmr_done
    |=> prog_busy && $stable(mode_q))
    else $error("reset aborted programming");

  a_irq_level: assert property (
    rie_q && gie_i && !prog_busy |=> nvm_ready_irq_o)
    else $error("ready request missing");

  a_irq_off: assert property (
    !rie_q || prog_busy |=> !nvm_ready_irq_o)
    else $error("ready request while disabled or busy");

  a_start_window: assert property (
    $rose(prog_busy) |-> $past(mpe_q) && $past(pe_wr))
    else $error("programming started without enable");

  a_mpe_timeout: assert property (
    mpe_wr ##1 s_mpe_quiet |=> !mpe_q)
    else $error("master enable outlived four cycles");

  a_mpe_hold: assert property (
    mpe_wr |=> mpe_q [*4])
    else $error("master enable dropped early");

  a_strobe_clear: assert property (
    $fell(prog_busy) |-> $past(tmr_done))
    else $error("strobe cleared before time elapsed");

  a_write_stall: assert property (
    start_ok |=> s_stall_two)
    else $error("write stall not two cycles");

  a_read_stall: assert property (
    read_ok |=> s_stall_four)
    else $error("read stall not four cycles");

  a_busy_freeze: assert property (
    prog_busy |=> $stable(addr_q))
    else $error("address changed during programming");

  a_busy_no_read: assert property (
    prog_busy && re_wr |=> !cpu_stall_o || $past(cpu_stall_o))
    else $error("read accepted during programming");

  a_flash_block: assert property (
    pe_wr && flash_selfprog_busy_i && !prog_busy |=> !prog_busy)
    else $error("write started during flash programming");

  a_resv_mode: assert property (
    pe_wr && mode_q == NVAC_PM_RESV && !prog_busy |=> !prog_busy)
    else $error("reserved mode started programming");

  a_op_capture: assert property (
    start_ok |=> op_data_q == $past(data_q) && op_addr_q == $past(addr_q))
    else $error("operands not captured at the strobe");

endmodule : nvac_ctrl

/* File: tb/nvac_cpu_model.sv */
// Purpose: CPU core model issuing I/O register accesses
// Assumes: requests launched on the falling edge, one per call
// Notes: a halted core issues nothing until the stall drops
`timescale 1ns/1ps
module nvac_cpu_model (
  input wire logic ref_clk_i,
  input wire logic cpu_stall_i,
  input wire logic [7:0] io_rdata_i,
  output logic [5:0] io_addr_o,
  output logic io_wr_o,
  output logic io_rd_o,
  output logic [7:0] io_wdata_o
);
  initial begin
    io_addr_o = 6'h00;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_wdata_o = 8'h00;
  end
  task automatic hold_off();
    @(negedge ref_clk_i);
    while (cpu_stall_i !== 1'b0) @(negedge ref_clk_i);
  endtask : hold_off
  task automatic io_write(input logic [5:0] a, input logic [7:0] d);
    hold_off();
    io_addr_o = a;
    io_wdata_o = d;
    io_wr_o = 1'b1;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    io_wr_o = 1'b0;
    // released bus must not look like the last value
    io_wdata_o = ~d;
    io_addr_o = ~a;
  endtask : io_write
  task automatic io_read(input logic [5:0] a, output logic [7:0] d);
    hold_off();
    io_addr_o = a;
    io_rd_o = 1'b1;
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    io_rd_o = 1'b0;
    io_addr_o = ~a;
    d = io_rdata_i;
  endtask : io_read
endmodule : nvac_cpu_model

/* File: tb/tb.sv */
// Purpose: self-checking bench for the data EEPROM access block
// Assumes: shortened programming counts, CPU model on the port
// Notes: shadow array predicts cells; untouched cells stay unknown
`timescale 1ns/1ps
`include "nvac_defs.svh"
module tb import nvac_pkg::*;;
  localparam int ATOM = 8;
  localparam int SPLIT = 4;
  localparam logic [5:0] CTRL = `NVAC_OFF_CTRL;
  localparam logic [5:0] DATA = `NVAC_OFF_DATA;
  localparam logic [5:0] LO = `NVAC_OFF_ADDR_LO;
  localparam logic [5:0] HI = `NVAC_OFF_ADDR_HI;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic gie_i = 1'b0;
  logic flash_busy = 1'b0;
  logic [5:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic irq;
  logic stall;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int t0 = 0;
  logic [7:0] shadow [logic [11:0]];
  logic [11:0] ra;
  logic [7:0] rv;
  always #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) cyc++;
  nvac_ctrl #(.ATOMIC_RC_CYC(16'(ATOM)), .SPLIT_RC_CYC(16'(SPLIT))) uut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .io_addr_i(io_addr),
    .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata),
    .io_rdata_o(io_rdata), .gie_i(gie_i),
    .flash_selfprog_busy_i(flash_busy), .nvm_ready_irq_o(irq),
    .cpu_stall_o(stall));
  nvac_cpu_model cpu (.ref_clk_i(ref_clk_i), .cpu_stall_i(stall),
    .io_rdata_i(io_rdata), .io_addr_o(io_addr), .io_wr_o(io_wr),
    .io_rd_o(io_rd), .io_wdata_o(io_wdata));
  task automatic cmp8(input string w, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask : cmp8
  task automatic cmp1(input string w, input logic e, g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", w, e, g);
    end
  endtask : cmp1
  task automatic end_sim();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  function automatic logic [7:0] exp_byte(nvac_mode_t m, logic [7:0] o, d);
    case (m)
      NVAC_PM_ATOMIC: return d;
      NVAC_PM_ERASE: return 8'hFF;
      NVAC_PM_WRITE: return o & d;
      default: return o;
    endcase
  endfunction : exp_byte
  task automatic reg_chk(input string w, input logic [5:0] a,
                         input logic [7:0] e);
    logic [7:0] g;
    cpu.io_read(a, g);
    cmp8(w, e, g);
  endtask : reg_chk
  task automatic stall_chk(input int n);
    for (int i = 0; i < n; i++) begin
      cmp1("stall", 1'b1, stall);
      @(negedge ref_clk_i);
    end
    cmp1("stall end", 1'b0, stall);
  endtask : stall_chk
  task automatic set_addr(input logic [11:0] a);
    cpu.io_write(LO, a[7:0]);
    cpu.io_write(HI, {4'h0, a[11:8]});
  endtask : set_addr
  task automatic start(input logic [11:0] a, input logic [7:0] d,
                       input nvac_mode_t m);
    set_addr(a);
    cpu.io_write(DATA, d);
    cpu.io_write(CTRL, {2'h0, m, 4'h4});
    cpu.io_write(CTRL, {2'h0, m, 4'h6});
    t0 = cyc;
    stall_chk(2);
    repeat (5) @(negedge ref_clk_i);
    reg_chk("ctrl busy", CTRL, {2'h0, m, 4'h2});
    shadow[a] = exp_byte(m, shadow.exists(a) ? shadow[a] : 8'h00, d);
  endtask : start
  // polls the busy bit, then judges the elapsed programming time
  task automatic wait_idle(input int len);
    logic [7:0] st;
    int k;
    st = 8'h02;
    k = 0;
    while (st[1] !== 1'b0 && k < 1000) begin
      cpu.io_read(CTRL, st);
      k++;
    end
    cmp1("idle", 1'b0, st[1]);
    k = cyc - t0;
    // first RC tick may come on any of the first 31 cycles
    cmp1("prog time", 1'b1, k >= (len - 1) * 31 && k <= len * 31 + 40);
  endtask : wait_idle
  task automatic check_byte(input logic [11:0] a);
    set_addr(a);
    cpu.io_write(CTRL, 8'h01);
    stall_chk(4);
    reg_chk("byte", DATA, shadow[a]);
  endtask : check_byte
  task automatic do_reset();
    sys_rst_i = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
  endtask : do_reset
  initial begin
    #200000;
    n_errors++;
    $display("[ERR] watchdog expected finish seen hang");
    end_sim();
  end
  initial begin
    void'($urandom(32'h0AF5C721));
    repeat (8) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    reg_chk("ctrl reset", CTRL, 8'h00);
    // reserved bits set on purpose to see them read back zero
    cpu.io_write(HI, 8'hFF);
    reg_chk("addr hi", HI, 8'h0F);
    cpu.io_write(CTRL, 8'hC0);
    reg_chk("ctrl top", CTRL, 8'h00);
    for (int i = 0; i < 5; i++) begin
      ra = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($urandom);
      start(ra, 8'($urandom), NVAC_PM_ATOMIC);
      wait_idle(ATOM);
      check_byte(ra);
    end
    for (int i = 0; i < 2; i++) begin
      start(ra, 8'($urandom), i ? NVAC_PM_ERASE : NVAC_PM_WRITE);
      wait_idle(SPLIT);
      check_byte(ra);
    end
    start(12'h123, 8'hA5, NVAC_PM_ATOMIC);
    cpu.io_write(CTRL, 8'h20);
    cpu.io_write(LO, 8'h00);
    reg_chk("mode frozen", CTRL, 8'h02);
    reg_chk("addr frozen", LO, 8'h23);
    cpu.io_write(CTRL, 8'h01);
    cmp1("read refused", 1'b0, stall);
    reg_chk("data kept", DATA, 8'hA5);
    wait_idle(ATOM);
    check_byte(12'h123);
    cpu.io_write(CTRL, 8'h02);
    reg_chk("no enable", CTRL, 8'h00);
    cpu.io_write(CTRL, 8'h04);
    reg_chk("enable on", CTRL, 8'h04);
    reg_chk("enable held", CTRL, 8'h04);
    reg_chk("enable gone", CTRL, 8'h00);
    cpu.io_write(CTRL, 8'h02);
    reg_chk("late strobe", CTRL, 8'h00);
    flash_busy = 1'b1;
    cpu.io_write(CTRL, 8'h04);
    cpu.io_write(CTRL, 8'h06);
    // the second write sets the enable again, but nothing may start
    reg_chk("flash busy", CTRL, 8'h04);
    flash_busy = 1'b0;
    cpu.io_write(CTRL, 8'h34);
    cpu.io_write(CTRL, 8'h36);
    repeat (5) @(negedge ref_clk_i);
    reg_chk("reserved mode", CTRL, 8'h30);
    gie_i = 1'b1;
    cpu.io_write(CTRL, 8'h08);
    @(negedge ref_clk_i);
    cmp1("irq on", 1'b1, irq);
    gie_i = 1'b0;
    @(negedge ref_clk_i);
    cmp1("irq gie off", 1'b0, irq);
    gie_i = 1'b1;
    cpu.io_write(CTRL, 8'h0C);
    cpu.io_write(CTRL, 8'h0E);
    t0 = cyc;
    repeat (2) @(negedge ref_clk_i);
    cmp1("irq busy", 1'b0, irq);
    wait_idle(ATOM);
    @(negedge ref_clk_i);
    cmp1("irq ready", 1'b1, irq);
    cpu.io_write(CTRL, 8'h00);
    @(negedge ref_clk_i);
    cmp1("irq cleared", 1'b0, irq);
    gie_i = 1'b0;
    start(ra, 8'($urandom), NVAC_PM_WRITE);
    do_reset();
    reg_chk("mode kept", CTRL, 8'h22);
    wait_idle(SPLIT);
    check_byte(ra);
    do_reset();
    reg_chk("mode cleared", CTRL, 8'h00);
    end_sim();
  end
endmodule : tb
